// ### shared/wdc_pkg.sv
// Constants, register map and field layout of the watchdog configuration decoder
package wdc_pkg;

   // ---------------------------------------------------------------
   // Bus widths
   // ---------------------------------------------------------------
   localparam int ADDR_W = 4;                   // Register index width
   localparam int DATA_W = 16;                  // Register data width
   localparam int CFG_W  = 14;                  // Configuration word width
   localparam int EV_W   = 6;                   // Number of event bits

   // ---------------------------------------------------------------
   // Register indices
   // ---------------------------------------------------------------
   localparam logic [3:0] REG_CFG    = 4'h0;    // Configuration word, read only
   localparam logic [3:0] REG_CTRL   = 4'h1;    // Control zero
   localparam logic [3:0] REG_WINDOW = 4'h2;    // Active window size
   localparam logic [3:0] REG_PERIOD = 4'h3;    // Active period
   localparam logic [3:0] REG_STATUS = 4'h4;    // Sticky events, read clears
   localparam logic [3:0] REG_MASK   = 4'h5;    // Interrupt mask
   localparam logic [3:0] REG_STATE  = 4'h6;    // Decoded live state

   // ---------------------------------------------------------------
   // Configuration word field positions
   // ---------------------------------------------------------------
   localparam int CLK_HI  = 13;                 // Clock selector
   localparam int CLK_LO  = 11;
   localparam int WIN_HI  = 10;                 // Window selector
   localparam int WIN_LO  = 8;
   localparam int UNUSED_BIT = 7;               // Always reads one
   localparam int MODE_HI = 6;                  // Run mode
   localparam int MODE_LO = 5;
   localparam int PER_HI  = 4;                  // Period selector
   localparam int PER_LO  = 0;

   localparam logic [13:0] CFG_BLANK = 14'h3fff; // Erased word reads all ones

   // ---------------------------------------------------------------
   // Field encodings
   // ---------------------------------------------------------------
   localparam logic [2:0] CLK_LF   = 3'h0;      // Low frequency oscillator
   localparam logic [2:0] CLK_MF   = 3'h1;      // Mid oscillator divided by 16
   localparam logic [2:0] CLK_SOFT = 3'h7;      // Software chooses

   localparam logic [2:0] WIN_SOFT   = 3'h7;    // Fully open, software owned
   localparam logic [2:0] WIN_MAXFIX = 3'h5;    // Highest fixed window code

   localparam logic [4:0] PER_SOFT   = 5'h1f;   // Software owned period
   localparam logic [4:0] PER_MAXLIN = 5'h12;   // Highest code that scales
   localparam logic [4:0] PER_BASE   = 5'h05;   // Log2 of the minimum ratio
   localparam logic [4:0] PER_SOFT_INIT = 5'h0b; // Initial value if software owned

   typedef enum logic [1:0] {
      WDC_MODE_OFF   = 2'b00,                   // Always disabled
      WDC_MODE_SOFT  = 2'b01,                   // Soft enable decides
      WDC_MODE_AWAKE = 2'b10,                   // Runs unless asleep
      WDC_MODE_ON    = 2'b11                    // Always runs
   } wdc_mode_t;

   // ---------------------------------------------------------------
   // Control and event bits
   // ---------------------------------------------------------------
   localparam int CTRL_SOFT_EN = 0;             // Soft watchdog enable
   localparam int CTRL_CLK_MF  = 1;             // Software clock choice

   localparam int EV_LOADED   = 0;              // Word loaded at power on
   localparam int EV_RSV_CLK  = 1;              // Reserved clock code seen
   localparam int EV_WIN_DENY = 2;              // Window write refused
   localparam int EV_PER_DENY = 3;              // Period write refused
   localparam int EV_EN_IGN   = 4;              // Soft enable write ignored
   localparam int EV_RUN_CHG  = 5;              // Run state changed

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam logic [1:0] LOAD_DLY = 2'h2;      // Cycles for pins to settle through sync

endpackage

// ### logic/wdc_word_store.sv
// Small store that holds the captured configuration word with a registered read port
`timescale 1ns/1ps
`default_nettype none

module wdc_word_store (
   input  wire logic                        clk,
   input  wire logic                        resetn,
   input  wire logic                        wr_en,
   input  wire logic [wdc_pkg::CFG_W-1:0]   wr_data,
   output logic      [wdc_pkg::CFG_W-1:0]   rd_data
);

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   logic [wdc_pkg::CFG_W-1:0] word_r;          // Held word

   // Capture on load; reset shows an erased word
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         word_r <= wdc_pkg::CFG_BLANK;
      end else if (wr_en) begin
         word_r <= wr_data;
      end
   end

   // Registered read port, one cycle behind the store
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_data <= wdc_pkg::CFG_BLANK;
      end else begin
         rd_data <= word_r;
      end
   end

endmodule

`default_nettype wire

// ### logic/wdc_top.sv
// Windowed watchdog configuration word decoder with software register port
`timescale 1ns/1ps
`default_nettype none

module wdc_top (
   input  wire logic                        clk,
   input  wire logic                        resetn,
   // Configuration word from non-volatile storage, asynchronous
   input  wire logic [wdc_pkg::CFG_W-1:0]   cfg_word_pin,
   input  wire logic                        sleep_pin,
   // Register port
   input  wire logic [wdc_pkg::ADDR_W-1:0]  reg_addr,
   input  wire logic [wdc_pkg::DATA_W-1:0]  reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic      [wdc_pkg::DATA_W-1:0]  reg_rdata,
   // Decoded watchdog controls
   output logic                             wdt_run,
   output logic                             clk_sel_lf,
   output logic                             clk_sel_mf,
   output logic      [2:0]                  window_size_active,
   output logic      [2:0]                  window_closed_eighths,
   output logic      [4:0]                  period_active,
   output logic      [4:0]                  prescale_log2,
   output logic                             keyed_access_required,
   output logic                             irq
);

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [wdc_pkg::CFG_W-1:0] cfg_meta_r;      // First stage, read only by second
   logic [wdc_pkg::CFG_W-1:0] cfg_sync_r;      // Settled configuration word
   logic                      sleep_meta_r;    // First stage
   logic                      sleep_sync_r;    // Settled sleep level

   // Two flops on every pin; reset shows an erased word
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cfg_meta_r   <= wdc_pkg::CFG_BLANK;
         cfg_sync_r   <= wdc_pkg::CFG_BLANK;
         sleep_meta_r <= 1'b0;
         sleep_sync_r <= 1'b0;
      end else begin
         cfg_meta_r   <= cfg_word_pin;
         cfg_sync_r   <= cfg_meta_r;
         sleep_meta_r <= sleep_pin;
         sleep_sync_r <= sleep_meta_r;
      end
   end

   // ---------------------------------------------------------------
   // Power-on load sequencing
   // ---------------------------------------------------------------
   logic [1:0] load_cnt_r;                     // Waits for the synchroniser
   logic       loaded_r;                       // Word has been taken
   logic       decode_ok_r;                    // Stored word visible on the read port
   logic       load_pulse;                     // One-cycle load strobe

   assign load_pulse = !loaded_r && (load_cnt_r == wdc_pkg::LOAD_DLY);

   // The word is taken once after release; later pin changes are ignored.
   // Decode waits one cycle more, because the store's read port lags the load
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         load_cnt_r  <= 2'h0;
         loaded_r    <= 1'b0;
         decode_ok_r <= 1'b0;
      end else begin
         decode_ok_r <= loaded_r;
         if (load_pulse) begin
            loaded_r <= 1'b1;
         end else if (!loaded_r) begin
            load_cnt_r <= load_cnt_r + 2'h1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Captured word and field split
   // ---------------------------------------------------------------
   logic [wdc_pkg::CFG_W-1:0] cfg_load;        // Word as stored, bit 7 forced
   logic [wdc_pkg::CFG_W-1:0] cfg_q;           // Stored word

   // Unused position always reads one whatever the pins say
   always_comb begin
      cfg_load = cfg_sync_r;
      cfg_load[wdc_pkg::UNUSED_BIT] = 1'b1;
   end

   wdc_word_store u_store (
      .clk     (clk),
      .resetn  (resetn),
      .wr_en   (load_pulse),
      .wr_data (cfg_load),
      .rd_data (cfg_q)
   );

   logic [2:0]           clk_code;             // Clock selector field
   logic [2:0]           win_code;             // Window selector field
   wdc_pkg::wdc_mode_t   run_mode;             // Operating mode field
   logic [4:0]           per_code;             // Period selector field
   logic [2:0]           win_code_ld;          // Window field at load time
   logic [4:0]           per_code_ld;          // Period field at load time
   logic [2:0]           clk_code_ld;          // Clock field at load time

   // Fields from the stored word, and from the settling word at load
   assign clk_code    = cfg_q[wdc_pkg::CLK_HI:wdc_pkg::CLK_LO];
   assign win_code    = cfg_q[wdc_pkg::WIN_HI:wdc_pkg::WIN_LO];
   assign run_mode    = wdc_pkg::wdc_mode_t'(cfg_q[wdc_pkg::MODE_HI:wdc_pkg::MODE_LO]);
   assign per_code    = cfg_q[wdc_pkg::PER_HI:wdc_pkg::PER_LO];
   assign win_code_ld = cfg_load[wdc_pkg::WIN_HI:wdc_pkg::WIN_LO];
   assign per_code_ld = cfg_load[wdc_pkg::PER_HI:wdc_pkg::PER_LO];
   assign clk_code_ld = cfg_load[wdc_pkg::CLK_HI:wdc_pkg::CLK_LO];

   // ---------------------------------------------------------------
   // Ownership decode
   // ---------------------------------------------------------------
   logic win_soft;                             // Software may set the window
   logic per_soft;                             // Software may set the period
   logic clk_soft;                             // Software picks the clock

   // Until the stored word is readable nothing is software owned, so the
   // blank word seen just after the load cannot unlock anything
   assign win_soft = decode_ok_r && (win_code == wdc_pkg::WIN_SOFT);
   assign per_soft = decode_ok_r && (per_code == wdc_pkg::PER_SOFT);
   assign clk_soft = decode_ok_r && (clk_code == wdc_pkg::CLK_SOFT);

   // ---------------------------------------------------------------
   // Register write decode
   // ---------------------------------------------------------------
   logic wr_ctrl;                              // Control zero written
   logic wr_win;                               // Window written
   logic wr_per;                               // Period written
   logic wr_mask;                              // Mask written
   logic rd_status;                            // Status read, clears it

   assign wr_ctrl   = reg_wr && (reg_addr == wdc_pkg::REG_CTRL);
   assign wr_win    = reg_wr && (reg_addr == wdc_pkg::REG_WINDOW);
   assign wr_per    = reg_wr && (reg_addr == wdc_pkg::REG_PERIOD);
   assign wr_mask   = reg_wr && (reg_addr == wdc_pkg::REG_MASK);
   assign rd_status = reg_rd && (reg_addr == wdc_pkg::REG_STATUS);

   // ---------------------------------------------------------------
   // Control zero
   // ---------------------------------------------------------------
   logic soft_watchdog_enable_r;               // Soft enable bit
   logic soft_clk_mf_r;                        // Software clock choice

   // Soft enable is only taken in the mode that uses it, so a stale
   // value cannot surprise anyone if the mode field is later reread
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         soft_watchdog_enable_r <= 1'b0;
      end else if (wr_ctrl && (run_mode == wdc_pkg::WDC_MODE_SOFT)) begin
         soft_watchdog_enable_r <= reg_wdata[wdc_pkg::CTRL_SOFT_EN];
      end
   end

   // Software clock choice counts only when the selector hands it over
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         soft_clk_mf_r <= 1'b0;
      end else if (wr_ctrl && clk_soft) begin
         soft_clk_mf_r <= reg_wdata[wdc_pkg::CTRL_CLK_MF];
      end
   end

   // ---------------------------------------------------------------
   // Active window size
   // ---------------------------------------------------------------
   // Load maps both top codes to fully open; later writes only when owned
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         window_size_active <= wdc_pkg::WIN_SOFT;
      end else if (load_pulse) begin
         window_size_active <= (win_code_ld > wdc_pkg::WIN_MAXFIX) ? wdc_pkg::WIN_SOFT
                                                                   : win_code_ld;
      end else if (wr_win && win_soft) begin
         window_size_active <= reg_wdata[2:0];
      end
   end

   // Closed share in eighths of the period: code 0 is 7/8, code 5 is 2/8
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         window_closed_eighths <= 3'h0;
      end else begin
         window_closed_eighths <= (window_size_active > wdc_pkg::WIN_MAXFIX) ? 3'h0
                                  : 3'h7 - window_size_active;
      end
   end

   // Keyed access is needed whenever the window is fixed by the word
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         keyed_access_required <= 1'b0;
      end else begin
         keyed_access_required <= decode_ok_r && !win_soft;
      end
   end

   // ---------------------------------------------------------------
   // Active period
   // ---------------------------------------------------------------
   // Fixed codes load as printed; the software code starts at a mid value
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         period_active <= 5'h00;
      end else if (load_pulse) begin
         period_active <= (per_code_ld == wdc_pkg::PER_SOFT) ? wdc_pkg::PER_SOFT_INIT
                                                             : per_code_ld;
      end else if (wr_per && per_soft) begin
         period_active <= reg_wdata[4:0];
      end
   end

   // Ratio exponent rises by one per code up to 18; above that the minimum
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prescale_log2 <= wdc_pkg::PER_BASE;
      end else begin
         prescale_log2 <= (period_active > wdc_pkg::PER_MAXLIN) ? wdc_pkg::PER_BASE
                          : wdc_pkg::PER_BASE + period_active;
      end
   end

   // ---------------------------------------------------------------
   // Reference clock choice
   // ---------------------------------------------------------------
   logic sel_mf;                               // Mid oscillator wanted

   // Reserved codes fall back to the default oscillator
   assign sel_mf = (clk_code == wdc_pkg::CLK_MF) || (clk_soft && soft_clk_mf_r);

   // Exactly one select is high once loaded; both low before that
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         clk_sel_lf <= 1'b0;
         clk_sel_mf <= 1'b0;
      end else begin
         clk_sel_lf <= decode_ok_r && !sel_mf;
         clk_sel_mf <= decode_ok_r && sel_mf;
      end
   end

   // ---------------------------------------------------------------
   // Run decision
   // ---------------------------------------------------------------
   logic run_nxt;                              // Watchdog should count
   // Mode field decides; the soft enable only counts in its own mode
   always_comb begin
      unique case (run_mode)
         wdc_pkg::WDC_MODE_ON:    run_nxt = 1'b1;
         wdc_pkg::WDC_MODE_AWAKE: run_nxt = !sleep_sync_r;
         wdc_pkg::WDC_MODE_SOFT:  run_nxt = soft_watchdog_enable_r;
         wdc_pkg::WDC_MODE_OFF:   run_nxt = 1'b0;
      endcase
   end

   // Held low until the word is loaded so no spurious run at power on
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wdt_run <= 1'b0;
      end else begin
         wdt_run <= decode_ok_r && run_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Events, status and interrupt
   // ---------------------------------------------------------------
   logic [wdc_pkg::EV_W-1:0] ev;               // One-cycle event pulses
   logic [wdc_pkg::EV_W-1:0] status_r;         // Sticky status
   logic [wdc_pkg::EV_W-1:0] mask_r;           // Interrupt mask

   always_comb begin
      ev = '0;
      ev[wdc_pkg::EV_LOADED]   = load_pulse;
      ev[wdc_pkg::EV_RSV_CLK]  = load_pulse && (clk_code_ld != wdc_pkg::CLK_LF)
                                 && (clk_code_ld != wdc_pkg::CLK_MF)
                                 && (clk_code_ld != wdc_pkg::CLK_SOFT);
      ev[wdc_pkg::EV_WIN_DENY] = wr_win && !win_soft;
      ev[wdc_pkg::EV_PER_DENY] = wr_per && !per_soft;
      ev[wdc_pkg::EV_EN_IGN]   = wr_ctrl && (run_mode != wdc_pkg::WDC_MODE_SOFT);
      ev[wdc_pkg::EV_RUN_CHG]  = (decode_ok_r && run_nxt) != wdt_run;
   end

   // A read clears, but an event in the same cycle stays set
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         status_r <= '0;
      end else begin
         status_r <= (rd_status ? '0 : status_r) | ev;
      end
   end

   // Mask starts closed
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mask_r <= '0;
      end else if (wr_mask) begin
         mask_r <= reg_wdata[wdc_pkg::EV_W-1:0];
      end
   end

   // Level interrupt, registered, one cycle behind status
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_r & mask_r);
      end
   end

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   logic [wdc_pkg::DATA_W-1:0] rd_mux;         // Selected read value

   // Unmapped indices read zero; bits above each field read zero
   always_comb begin
      rd_mux = '0;
      unique case (reg_addr)
         wdc_pkg::REG_CFG:    rd_mux[wdc_pkg::CFG_W-1:0] = cfg_q;
         wdc_pkg::REG_CTRL: begin
            rd_mux[wdc_pkg::CTRL_SOFT_EN] = soft_watchdog_enable_r;
            rd_mux[wdc_pkg::CTRL_CLK_MF]  = soft_clk_mf_r;
         end
         wdc_pkg::REG_WINDOW: rd_mux[2:0] = window_size_active;
         wdc_pkg::REG_PERIOD: rd_mux[4:0] = period_active;
         wdc_pkg::REG_STATUS: rd_mux[wdc_pkg::EV_W-1:0] = status_r;
         wdc_pkg::REG_MASK:   rd_mux[wdc_pkg::EV_W-1:0] = mask_r;
         wdc_pkg::REG_STATE: begin
            rd_mux[5:0] = {loaded_r, per_soft, win_soft, keyed_access_required,
                           clk_sel_mf, wdt_run};
         end
         default:             rd_mux = '0;
      endcase
   end

   // Data stand in the cycle after the strobe only, zero otherwise
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : '0;
      end
   end

endmodule

`default_nettype wire

// ### dv/wdc_top_props.sv
// Assertions on the watchdog decoder ports
`timescale 1ns/1ps
`default_nettype none
module wdc_top_props (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic [13:0] cfg_word_pin,
   input wire logic        sleep_pin,
   input wire logic        wdt_run,
   input wire logic        clk_sel_lf,
   input wire logic        clk_sel_mf,
   input wire logic [2:0]  window_size_active,
   input wire logic [2:0]  window_closed_eighths,
   input wire logic [4:0]  period_active,
   input wire logic [4:0]  prescale_log2,
   input wire logic        keyed_access_required
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   logic [1:0] md;   // Run mode field of the word
   logic       ok;   // Decode has settled once a clock is chosen
   assign md = cfg_word_pin[6:5];
   assign ok = clk_sel_lf | clk_sel_mf;
   property p_win;
      window_size_active < 3'h6 |=> window_closed_eighths == 3'h7 - $past(window_size_active);
   endproperty
   a_win: assert property (p_win) else $error("closed part wrong");
   property p_pre;
      period_active < 5'h13 |=> prescale_log2 == $past(period_active) + 5'h05;
   endproperty
   a_pre: assert property (p_pre) else $error("prescale wrong");
   property p_pmin;
      period_active inside {[5'h13:5'h1e]} |=> prescale_log2 == 5'h05;
   endproperty
   a_pmin: assert property (p_pmin) else $error("minimum ratio wrong");
   // A locked window must never move, whatever software writes
   property p_lock; keyed_access_required |=> $stable(window_size_active); endproperty
   a_lock: assert property (p_lock) else $error("locked window moved");
   property p_on; ok && md == 2'b11 |-> wdt_run; endproperty
   a_on: assert property (p_on) else $error("always-on not running");
   property p_off; md == 2'b00 |-> !wdt_run; endproperty
   a_off: assert property (p_off) else $error("disabled mode running");
   // Sleep passes two sync flops and an output flop, so four steady samples
   property p_sleep;
      (ok && md == 2'b10 && $stable(sleep_pin)) [*4] |-> wdt_run == !sleep_pin;
   endproperty
   a_sleep: assert property (p_sleep) else $error("awake mode wrong");
   property p_clk;
      ok && cfg_word_pin[13:12] == 2'b00 |-> clk_sel_mf == cfg_word_pin[11];
   endproperty
   a_clk: assert property (p_clk) else $error("clock choice wrong");
endmodule
bind wdc_top wdc_top_props u_props (.clk(clk), .resetn(resetn), .cfg_word_pin(cfg_word_pin),
   .sleep_pin(sleep_pin), .wdt_run(wdt_run), .clk_sel_lf(clk_sel_lf), .clk_sel_mf(clk_sel_mf),
   .window_size_active(window_size_active), .window_closed_eighths(window_closed_eighths),
   .period_active(period_active), .prescale_log2(prescale_log2),
   .keyed_access_required(keyed_access_required));
`default_nettype wire

// ### dv/wdc_top_tb.sv
// Self-checking bench for the watchdog configuration decoder
`timescale 1ns/1ps
`default_nettype none
module wdc_top_tb;
   logic        clk, resetn, sleep_pin, reg_wr, reg_rd, wdt_run, lf, mf_o, irq, keyed;
   logic [2:0]  win_a, win_c;
   logic [4:0]  per_a, pre;
   logic [13:0] cfg_word_pin, w;
   logic [3:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, seed;
   int          n_fail, cmp_count, cw, ww, md, pw, win, per, run, mf, st, sv;
   // Every run mode, clock class and window/period edge code
   logic [13:0] words [6] = '{14'h00e0, 14'h0dd2, 14'h3fbf, 14'h1e93, 14'h33be, 14'h3fff};
   wdc_top u_dut (.clk(clk), .resetn(resetn), .cfg_word_pin(cfg_word_pin),
      .sleep_pin(sleep_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wdt_run(wdt_run), .clk_sel_lf(lf),
      .clk_sel_mf(mf_o), .window_size_active(win_a), .window_closed_eighths(win_c),
      .period_active(per_a), .prescale_log2(pre), .keyed_access_required(keyed), .irq(irq));
   initial begin
      clk = 0;
      forever #10 clk = ~clk;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clk) reg_wr <= 0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
      @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge clk) reg_rd <= 0;
      #1 chk(reg_rdata & m, e);
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      {resetn, sleep_pin, reg_wr, reg_rd, reg_addr, reg_wdata, cfg_word_pin} = '0;
      seed = 16'h0054;
      for (int i = 0; i < 10; i++) begin
         if (i < 6) w = words[i];
         else begin
            seed = lfsr(seed);
            w = seed[13:0];
         end
         // Word pins change only under reset; later changes would be ignored
         @(posedge clk);
         resetn <= 0;
         cfg_word_pin <= w;
         repeat (i ? 3 : 20) @(posedge clk);
         resetn <= 1;
         repeat (8) @(posedge clk);
         cw = w[13:11]; ww = w[10:8]; md = w[6:5]; pw = w[4:0];
         win = ww > 5 ? 7 : ww;
         per = pw == 31 ? 11 : pw;
         mf = cw == 1;
         run = md >= 2;
         #1 chk(win_a, win);
         chk(pre, per < 19 ? per + 5 : 5);
         chk(mf_o, mf);
         chk(lf, !mf);
         chk(keyed, ww != 7);
         chk(wdt_run, run);
         chk(irq, 0);
         rd(wdc_pkg::REG_CFG, w | 14'h0080, 16'hffff);
         wr(wdc_pkg::REG_MASK, 16'h0001);
         wr(wdc_pkg::REG_WINDOW, 16'h0003);
         wr(wdc_pkg::REG_PERIOD, 16'h0004);
         wr(wdc_pkg::REG_CTRL, 16'h0003);
         if (ww == 7) win = 3;
         if (pw == 31) per = 4;
         if (md == 1) run = 1;
         if (cw == 7) mf = 1;
         st = 1 + (cw > 1 && cw < 7 ? 2 : 0) + (ww != 7 ? 4 : 0) + (pw != 31 ? 8 : 0);
         st = st + (md != 1 ? 16 : 0) + (md != 0 ? 32 : 0);
         sv = 32 + (pw == 31) * 16 + (ww == 7 ? 8 : 4) + mf * 2 + run;
         repeat (3) @(posedge clk);
         #1 chk(win_a, win);
         chk(per_a, per);
         chk(wdt_run, run);
         chk(mf_o, mf);
         chk(irq, 1);
         rd(wdc_pkg::REG_CTRL, (md == 1) + (cw == 7) * 2, 16'hffff);
         rd(wdc_pkg::REG_STATE, sv, 16'h003f);
         rd(wdc_pkg::REG_STATUS, st, 16'h003f);
         repeat (2) @(posedge clk);
         #1 chk(irq, 0);
         rd(wdc_pkg::REG_STATUS, 0, 16'h003f);
         rd(4'hf, 0, 16'hffff);
         if (md == 2) begin
            @(posedge clk) sleep_pin <= 1;
            repeat (5) @(posedge clk);
            #1 chk(wdt_run, 0);
            @(posedge clk) sleep_pin <= 0;
            repeat (5) @(posedge clk);
            #1 chk(wdt_run, 1);
         end
         $display("config %h checked", w);
      end
      results;
   end
endmodule
`default_nettype wire
